// *** common/pwm2_map.vh ***
`ifndef PWM2_MAP_VH
`define PWM2_MAP_VH

// ------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_TRIG_CTRL   12'h130
`define IDX_FILT_SEL    12'h131
`define IDX_MODE        12'h132
`define IDX_GEN_A       12'h134
`define IDX_GEN_B       12'h135
`define IDX_GEN_C       12'h136
`define IDX_GEN_D       12'h137
`define IDX_COUNT       12'h138

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_TRIG_CTRL   8'h18
`define RST_FILT_SEL    8'h00
`define RST_MODE        8'h00
`define RST_GEN         16'hFFFF

// ------------------------------------------------------------
// Field positions and masks
// ------------------------------------------------------------
`define TC_POL_B        0
`define TC_POL_C        1
`define TC_POL_D        2
`define TC_STOP         5
`define TC_EDGE_LO      6
`define TC_WMASK        8'hE7
`define TC_ONES         8'h18
`define FS_TRIG         4
`define FS_CLK_LO       6
`define FS_WMASK        8'hDF
`define MD_BUF_C        3
`define MD_BUF_D        4
`define MD_PWM2_LOW     5
`define MD_START        7
`define MD_WMASK        8'hBF

// ------------------------------------------------------------
// Mode and selector codes
// ------------------------------------------------------------
`define MODE_OC         3'h0
`define MODE_PWM        3'h1
`define MODE_PWM2       3'h2
`define MODE_CAP        3'h3
`define EDGE_OFF        2'h0
`define EDGE_RISE       2'h1
`define EDGE_FALL       2'h2
`define EDGE_BOTH       2'h3
`define FCLK_DIV32      2'h0
`define FCLK_DIV8       2'h1
`define FCLK_DIV1       2'h2
`define FCLK_SRC        2'h3

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define PRE_DIV8_LAST   5'h07
`define PRE_DIV32_LAST  5'h1F
`define FILT_SAMPLES    3

`endif

// *** logic/pwm2_mode_control.v ***
// Summary of operation
// - Polarity bit one makes channel high-active.
// - Polarity bits act only in PWM mode.
// - Control bits three and four read one.
// - Stop bit halts counting at period match.
// - Stop bit honoured in compare, PWM, PWM2.
// - Edge field picks off, rise, fall, both.
// - Edge field honoured only in PWM2 mode.
// - Filter bit routes capture pin through filter.
// - Capture filter bits need input capture.
// - Bit four filters the trigger pin.
// - Trigger filter needs PWM2 with trigger on.
// - Clock field picks div32, div8, div1, source.
// - Filter register bit five reads zero.
// - Register A sets period, output on B.
// - Register B match ends active level.
// - Register C match starts active level unless MD_BUF_C set.
// - Register D buffers next change point.
// - Register D unused with buffer bit clear.
// - Pin B starts inactive, C on, B off.
// - Selected trigger edge starts PWM output.
`timescale 1ns/100ps
`include "pwm2_map.vh"

module pwm2_mode_control #(
  parameter CW = 16
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          rst_b,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [13:0]   paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output wire          pready,
  output reg  [31:0]   prdata,
  output reg           pslverr,
  // Count source tick from the clock select logic
  input  wire          count_tick,
  // Pins
  input  wire [3:0]    timer_pin_in,
  input  wire          external_trigger_pin,
  output reg           timer_pin_b,
  output reg           timer_pin_c,
  output reg           timer_pin_d,
  // Conditioned capture levels and state
  output reg  [3:0]    capture_level,
  output reg           counting
);

  // ----------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------
  reg  [7:0]    pwm_trigger_control;
  reg  [7:0]    input_filter_select;
  reg  [7:0]    mode_ctrl;
  reg  [CW-1:0] general_reg_a;
  reg  [CW-1:0] general_reg_b;
  reg  [CW-1:0] general_reg_c;
  reg  [CW-1:0] general_reg_d;
  reg  [CW-1:0] count;
  reg           stopped;
  reg           lvl_b;
  reg           lvl_c;
  reg           lvl_d;
  reg  [4:0]    pre;
  reg  [4:0]    sync1;
  reg  [4:0]    sync2;
  reg           trig_prev;
  reg  [31:0]   next_prdata;
  reg           next_slverr;
  wire [11:0]   idx;
  wire          wr;
  wire          rd_setup;
  wire [2:0]    mode;
  wire          pwm2;
  wire [1:0]    edge_sel;
  wire [1:0]    fclk_sel;
  wire          trig_on;
  wire          stop_eff;
  wire          clear_at_a;
  wire          step;
  wire          match_a;
  wire          match_b;
  wire          match_c;
  wire          match_d;
  wire          trig_filt;
  wire          trig_rise;
  wire          trig_fall;
  wire          trig_ev;
  wire          f_tick;
  wire [4:0]    use_filt;
  wire [4:0]    filt_out;
  wire [CW-1:0] count_inc;

  assign idx      = paddr[13:2];
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign pready   = 1'b1;

  assign mode     = mode_ctrl[2:0];
  assign pwm2     = (mode == `MODE_PWM2);
  assign edge_sel = pwm_trigger_control[`TC_EDGE_LO+1:`TC_EDGE_LO];
  assign fclk_sel = input_filter_select[`FS_CLK_LO+1:`FS_CLK_LO];

  assign trig_on  = pwm2 & (edge_sel != `EDGE_OFF);

  assign stop_eff = pwm_trigger_control[`TC_STOP] & ((mode == `MODE_OC) | clear_at_a);
  assign clear_at_a = (mode == `MODE_PWM) | pwm2;

  assign step     = mode_ctrl[`MD_START] & ~stopped & count_tick;
  assign match_a  = step & (count == general_reg_a);
  assign match_b  = step & (count == general_reg_b);
  assign match_c  = step & (count == general_reg_c);
  assign match_d  = step & (count == general_reg_d);
  assign count_inc = count + {{(CW-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------
  // Pin synchronisers and filter sample clock
  // ----------------------------------------------------------

  // Two flops for every pin before any logic looks at it.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      pre   <= 5'h00;
    end else begin
      sync1 <= {external_trigger_pin, timer_pin_in};
      sync2 <= sync1;
      pre   <= pre + 5'h01;
    end
  end

  assign f_tick = (fclk_sel == `FCLK_DIV32) ? (pre == `PRE_DIV32_LAST) :
                  (fclk_sel == `FCLK_DIV8)  ? ({2'h0, pre[2:0]} == `PRE_DIV8_LAST) :
                  (fclk_sel == `FCLK_DIV1)  ? 1'b1 : count_tick;

  assign use_filt[3:0] = input_filter_select[3:0]
                         & {4{mode == `MODE_CAP}};
  assign use_filt[4] = input_filter_select[`FS_TRIG] & trig_on;

  // ----------------------------------------------------------
  // Digital noise filters, one per pin
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_filt
      reg [`FILT_SAMPLES-1:0] smp;
      reg                     held;
      // A new level passes once all samples agree.
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          smp  <= {`FILT_SAMPLES{1'b0}};
          held <= 1'b0;
        end else if (f_tick) begin
          smp <= {smp[`FILT_SAMPLES-2:0], sync2[gi]};
          if (&smp) begin
            held <= 1'b1;
          end else if (~|smp) begin
            held <= 1'b0;
          end
        end
      end
      assign filt_out[gi] = use_filt[gi] ? held : sync2[gi];
    end
  endgenerate

  // ----------------------------------------------------------
  // Trigger edge detection
  // ----------------------------------------------------------
  assign trig_filt = filt_out[4];
  assign trig_rise = trig_filt & ~trig_prev;
  assign trig_fall = ~trig_filt & trig_prev;

  assign trig_ev = trig_on & (
                   ((edge_sel == `EDGE_RISE) & trig_rise) |
                   ((edge_sel == `EDGE_FALL) & trig_fall) |
                   ((edge_sel == `EDGE_BOTH) & (trig_rise | trig_fall)));

  // Last trigger level and the conditioned capture levels.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_prev     <= 1'b0;
      capture_level <= 4'h0;
    end else begin
      trig_prev     <= trig_filt;
      capture_level <= filt_out[3:0];
    end
  end

  // ----------------------------------------------------------
  // Control and compare registers
  // ----------------------------------------------------------

  // Software writes; hardware buffer transfers win a same-cycle clash.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_trigger_control <= `RST_TRIG_CTRL;
      input_filter_select <= `RST_FILT_SEL;
      mode_ctrl           <= `RST_MODE;
      general_reg_a       <= `RST_GEN;
      general_reg_b       <= `RST_GEN;
      general_reg_c       <= `RST_GEN;
      general_reg_d       <= `RST_GEN;
    end else begin
      if (wr && pstrb[0]) begin
        case (idx)
          `IDX_TRIG_CTRL: pwm_trigger_control <=
              (pwdata[7:0] & `TC_WMASK) | `TC_ONES;
          `IDX_FILT_SEL: input_filter_select <= pwdata[7:0] & `FS_WMASK;
          `IDX_MODE: mode_ctrl <= pwdata[7:0] & `MD_WMASK;
          default: ;
        endcase
      end
      if (wr && idx == `IDX_GEN_A) begin
        if (pstrb[0]) general_reg_a[7:0] <= pwdata[7:0];
        if (pstrb[1]) general_reg_a[CW-1:8] <= pwdata[CW-1:8];
      end
      if (wr && idx == `IDX_GEN_B) begin
        if (pstrb[0]) general_reg_b[7:0] <= pwdata[7:0];
        if (pstrb[1]) general_reg_b[CW-1:8] <= pwdata[CW-1:8];
      end
      if (wr && idx == `IDX_GEN_C) begin
        if (pstrb[0]) general_reg_c[7:0] <= pwdata[7:0];
        if (pstrb[1]) general_reg_c[CW-1:8] <= pwdata[CW-1:8];
      end
      if (wr && idx == `IDX_GEN_D) begin
        if (pstrb[0]) general_reg_d[7:0] <= pwdata[7:0];
        if (pstrb[1]) general_reg_d[CW-1:8] <= pwdata[CW-1:8];
      end
      if (pwm2 && match_a && mode_ctrl[`MD_BUF_D]) begin
        general_reg_b <= general_reg_d;
      end
      if (pwm2 && match_a && mode_ctrl[`MD_BUF_C]) begin
        general_reg_a <= general_reg_c;
      end
      if (match_a && stop_eff && !trig_on) begin
        mode_ctrl[`MD_START] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Counter
  // ----------------------------------------------------------

  // Counter clears at period match in the PWM modes, else wraps free.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count   <= {CW{1'b0}};
      stopped <= 1'b0;
    end else begin
      if (wr && idx == `IDX_COUNT) begin
        count <= pwdata[CW-1:0];
      end else if (trig_ev) begin
        count <= {CW{1'b0}};
      end else if (match_a && clear_at_a) begin
        count <= {CW{1'b0}};
      end else if (step) begin
        count <= count_inc;
      end
      if (trig_ev) begin
        stopped <= 1'b0;
      end else if (match_a && stop_eff && trig_on) begin
        stopped <= 1'b1;
      end else if (!trig_on) begin
        stopped <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Waveform levels
  // ----------------------------------------------------------

  // Internal level is one while the output is active.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_b <= 1'b0;
      lvl_c <= 1'b0;
      lvl_d <= 1'b0;
    end else if (pwm2) begin
      lvl_c <= 1'b0;
      lvl_d <= 1'b0;
      if (trig_ev || !mode_ctrl[`MD_START]) begin
        lvl_b <= 1'b0;
      end else if (match_b) begin
        lvl_b <= 1'b0;
      end else if (match_c && !mode_ctrl[`MD_BUF_C]) begin
        lvl_b <= 1'b1;
      end
    end else if (mode == `MODE_PWM) begin
      // Active from channel match to period match.
      if (match_a || !mode_ctrl[`MD_START]) begin
        lvl_b <= 1'b0;
        lvl_c <= 1'b0;
        lvl_d <= 1'b0;
      end else begin
        if (match_b) lvl_b <= 1'b1;
        if (match_c) lvl_c <= 1'b1;
        if (match_d) lvl_d <= 1'b1;
      end
    end else begin
      lvl_b <= 1'b0;
      lvl_c <= 1'b0;
      lvl_d <= 1'b0;
    end
  end

  // Pin levels from flops, polarity applied per mode.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_pin_b <= 1'b0;
      timer_pin_c <= 1'b0;
      timer_pin_d <= 1'b0;
      counting    <= 1'b0;
    end else begin
      counting <= mode_ctrl[`MD_START] & ~stopped;
      if (pwm2) begin
        timer_pin_b <= lvl_b ^ mode_ctrl[`MD_PWM2_LOW];
        timer_pin_c <= 1'b0;
        timer_pin_d <= 1'b0;
      end else if (mode == `MODE_PWM) begin
        timer_pin_b <= ~(lvl_b ^ pwm_trigger_control[`TC_POL_B]);
        timer_pin_c <= ~(lvl_c ^ pwm_trigger_control[`TC_POL_C]);
        timer_pin_d <= ~(lvl_d ^ pwm_trigger_control[`TC_POL_D]);
      end else begin
        timer_pin_b <= 1'b0;
        timer_pin_c <= 1'b0;
        timer_pin_d <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------

  // Read data is chosen in the setup cycle and held for the access.
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (idx)
      `IDX_TRIG_CTRL: next_prdata[7:0] = pwm_trigger_control;
      `IDX_FILT_SEL:  next_prdata[7:0] = input_filter_select;
      `IDX_MODE:      next_prdata[7:0] = mode_ctrl;
      `IDX_GEN_A:     next_prdata[CW-1:0] = general_reg_a;
      `IDX_GEN_B:     next_prdata[CW-1:0] = general_reg_b;
      `IDX_GEN_C:     next_prdata[CW-1:0] = general_reg_c;
      `IDX_GEN_D:     next_prdata[CW-1:0] = general_reg_d;
      `IDX_COUNT:     next_prdata[CW-1:0] = count;
      default:        next_slverr = 1'b1;
    endcase
  end

  // Capture the answer at the setup edge.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_slverr;
    end
  end

endmodule // pwm2_mode_control

// *** test/pwm2_monitor.sv ***
`timescale 1ns/100ps
// ----------
// Bus checker
// ----------
module pwm2_monitor (
  // Clock and reset
  input wire        core_clk,
  input wire        rst_b,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr
);
  // Decode of the request seen on the bus.
  wire [11:0] idx      = paddr[13:2];
  wire        setup    = psel && !penable;
  wire        rd_setup = setup && !pwrite;
  wire        mapped   = idx >= 12'h130 && idx <= 12'h138 && idx != 12'h133;
  wire        wr_lane  = psel && penable && pwrite && pstrb[0];
  reg  [7:0]  tc_sh;
  reg  [7:0]  fs_sh;

  // Shadow copies of the control and filter byte registers, fixed bits forced.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tc_sh <= 8'h18;
      fs_sh <= 8'h00;
    end else if (wr_lane && idx == 12'h130) begin
      tc_sh <= (pwdata[7:0] & 8'hE7) | 8'h18;
    end else if (wr_lane && idx == 12'h131) begin
      fs_sh <= pwdata[7:0] & 8'hDF;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_ready_const: assert property (pready) else $error("pready low");
  a_err_unmap:
    assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_map:
    assert property (setup && mapped |=> !pslverr) else $error("mapped access refused");
  a_ones_read:
    assert property (rd_setup && idx == 12'h130 |=> prdata[4:3] == 2'h3)
    else $error("control bits three and four not one");
  a_zero_read:
    assert property (rd_setup && idx == 12'h131 |=> !prdata[5])
    else $error("filter bit five not zero");
  a_tc_back:
    assert property (rd_setup && idx == 12'h130 |=> prdata[7:0] == tc_sh)
    else $error("control readback wrong");
  a_fs_back:
    assert property (rd_setup && idx == 12'h131 |=> prdata[7:0] == fs_sh)
    else $error("filter readback wrong");
  a_data_hold:
    assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved in access phase");
endmodule // pwm2_monitor

bind pwm2_mode_control pwm2_monitor mon (.core_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr);

// *** test/pin_partner.sv ***
`timescale 1ns/100ps
// ----------
// Pin partner
// ----------
module pin_partner (
  // Clock
  input  wire       core_clk,
  // Waveform pin watched
  input  wire       timer_pin_b,
  // Pins driven
  output reg        external_trigger_pin,
  output reg  [3:0] timer_pin_in
);
  integer hi_count;

  // Pins start low and the high-cycle count starts at zero.
  initial begin
    external_trigger_pin = 1'h0;
    timer_pin_in = 4'h0;
    hi_count = 0;
  end

  // Counts the cycles in which the waveform pin is high.
  always @(posedge core_clk) begin
    hi_count <= hi_count + (timer_pin_b === 1'h1);
  end

  task set_trig(input v);
    begin
      @(posedge core_clk);
      external_trigger_pin <= v;
    end
  endtask

  // Sets the capture pin levels just after an edge.
  task set_pins(input [3:0] v);
    begin
      @(posedge core_clk);
      timer_pin_in <= v;
    end
  endtask
endmodule // pin_partner

// *** test/tb_pwm2_mode_control.sv ***
`timescale 1ns/100ps
// ----------
// Bench top
// ----------
module tb_pwm2_mode_control;
  reg         core_clk, rst_b, psel, penable, pwrite, count_tick, err_v;
  reg  [13:0] paddr;
  reg  [31:0] pwdata, rd_v;
  reg  [3:0]  pstrb;
  wire        pready, pslverr, external_trigger_pin, counting;
  wire        timer_pin_b, timer_pin_c, timer_pin_d;
  wire [31:0] prdata;
  wire [3:0]  timer_pin_in, capture_level;
  integer     n_mismatch, check_count, i, k, h0;
  int         pa, pb, pc, pd, tc_m, fs_m, v, s, pol, hc, hd;

  pwm2_mode_control dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .count_tick, .timer_pin_in, .external_trigger_pin,
    .timer_pin_b, .timer_pin_c, .timer_pin_d, .capture_level, .counting);
  pin_partner partner (.core_clk, .timer_pin_b, .external_trigger_pin, .timer_pin_in);

  // Free-running bus clock.
  always #20 core_clk = ~core_clk;

  // Compares one value and counts the result.
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask

  // Prints the verdict and ends the run.
  task close_out;
    begin
      if (n_mismatch == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // One APB transfer: setup, then access until pready.
  task apb(input [11:0] idx, input w, input [31:0] d, input [3:0] st);
    begin
      @(posedge core_clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= {idx, 2'h0};
      pwdata  <= d;
      pstrb   <= st;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1) @(posedge core_clk);
      rd_v  = prdata;
      err_v = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  // Full-word write.
  task wr(input [11:0] idx, input [31:0] d);
    apb(idx, 1'h1, d, 4'hF);
  endtask

  // Read compared with the expected value, no error expected.
  task rd_chk(input string nm, input [11:0] idx, input [31:0] exp);
    begin
      apb(idx, 1'h0, 32'h0, 4'hF);
      chk(nm, rd_v, exp);
      chk("slverr", err_v, 32'h0);
    end
  endtask

  // Settles two periods, then counts high cycles of each waveform pin over four.
  task measure;
    begin
      repeat (2 * (pa + 1)) @(posedge core_clk);
      h0 = partner.hi_count;
      hc = 0;
      hd = 0;
      repeat (4 * (pa + 1)) begin
        @(posedge core_clk);
        hc = hc + timer_pin_c;
        hd = hd + timer_pin_d;
      end
      h0 = partner.hi_count - h0;
    end
  endtask

  // Hang guard.
  initial begin
    #800000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end

  // Main sequence.
  initial begin
    core_clk = 1'h0;
    rst_b = 1'h0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
    count_tick = 1'h1;
    n_mismatch = 0;
    check_count = 0;
    void'($urandom(32'hE3B05EFB));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    rd_chk("trig_ctrl", 12'h130, 32'h18);
    rd_chk("filt_sel", 12'h131, 32'h0);
    for (i = 0; i < 4; i = i + 1) rd_chk("gen_reg", 12'h134 + i, 32'hFFFF);
    tc_m = 'h18;
    fs_m = 0;
    for (i = 0; i < 8; i = i + 1) begin
      v = $urandom;
      s = $urandom;
      apb(12'h130, 1'h1, v, s[3:0]);
      apb(12'h131, 1'h1, v >> 8, s[3:0]);
      if (s[0]) begin
        tc_m = (v & 'hE7) | 'h18;
        fs_m = (v >> 8) & 'hDF;
      end
      rd_chk("trig_ctrl", 12'h130, tc_m);
      rd_chk("filt_sel", 12'h131, fs_m);
    end
    apb(12'h133, 1'h1, 32'hFF, 4'hF);
    chk("unmapped_err", err_v, 32'h1);
    apb(12'h133, 1'h0, 32'h0, 4'hF);
    chk("unmapped_rd", rd_v, 32'h0);
    chk("unmapped_err", err_v, 32'h1);
    // PWM2 waveform plain, low-active, then with register D buffering.
    pol = $urandom % 8;
    wr(12'h130, pol);
    pa = 40 + $urandom % 40;
    pc = 1 + $urandom % 10;
    // keeps B and D apart from C
    pb = pc + 1 + $urandom % (pa - pc - 1);
    pd = pc + 1 + $urandom % (pa - pc - 1);
    wr(12'h134, pa);
    wr(12'h135, pb);
    wr(12'h136, pc);
    wr(12'h137, pd);
    for (k = 0; k < 3; k = k + 1) begin
      wr(12'h132, k == 0 ? 32'h82 : k == 1 ? 32'hA2 : 32'h92);
      measure;
      v = k == 1 ? pa + 1 - pb + pc : (k == 2 ? pd : pb) - pc;
      chk("high_cycles", h0, 4 * v);
      chk("pin_c_idle", hc, 0);
      chk("pin_d_idle", hd, 0);
      rd_chk("gen_reg_b", 12'h135, k == 2 ? pd : pb);
      wr(12'h132, 32'h0);
    end
    // Ordinary PWM mode: each channel active from its match to the period end.
    wr(12'h135, pb);
    wr(12'h132, 32'h81);
    measure;
    chk("pwm_pin_b", h0, 4 * (pol[0] ? pa - pb : pb + 1));
    chk("pwm_pin_c", hc, 4 * (pol[1] ? pa - pc : pc + 1));
    chk("pwm_pin_d", hd, 4 * (pol[2] ? pa - pd : pd + 1));
    wr(12'h132, 32'h0);
    // Period-match stop, free running, stop ignored in capture, stop in compare.
    for (k = 0; k < 4; k = k + 1) begin
      wr(12'h130, k == 1 ? 32'h0 : 32'h20);
      wr(12'h138, 32'h0);
      wr(12'h132, k == 2 ? 32'h83 : k == 3 ? 32'h80 : 32'h82);
      repeat (2 * (pa + 1)) @(posedge core_clk);
      chk("counting", counting, k == 1 || k == 2);
      wr(12'h132, 32'h0);
    end
    // Each trigger edge code, then each filter clock on a short pulse.
    wr(12'h134, 32'h78);
    wr(12'h131, 32'h0);
    for (k = 0; k < 8; k = k + 1) begin
      if (k > 3) wr(12'h131, 32'h10 | (k - 4) << 6);
      wr(12'h130, k > 3 ? 32'h60 : 32'h20 | k << 6);
      wr(12'h138, 32'h0);
      wr(12'h132, 32'h82);
      repeat (300) @(posedge core_clk);
      partner.set_trig(1'h1);
      repeat (k > 3 ? 40 : 20) @(posedge core_clk);
      if (k > 3) begin
        partner.set_trig(1'h0);
        repeat (5) @(posedge core_clk);
        chk("filtered_start", counting, k != 4);
      end else begin
        chk("rise_start", counting, k % 2);
        repeat (300) @(posedge core_clk);
        partner.set_trig(1'h0);
        repeat (20) @(posedge core_clk);
        chk("fall_start", counting, k / 2);
      end
      wr(12'h132, 32'h0);
    end
    // Capture pin filter only in capture mode, then on a stalled and a running count source.
    for (k = 0; k < 4; k = k + 1) begin
      wr(12'h131, k > 1 ? 32'hC1 : 32'h1);
      wr(12'h132, k == 1 ? 32'h2 : 32'h3);
      count_tick <= k != 2;
      partner.set_pins(4'hF);
      repeat (20) @(posedge core_clk);
      chk("capture_level", capture_level, k % 2 ? 32'hF : 32'hE);
      partner.set_pins(4'h0);
      repeat (200) @(posedge core_clk);
    end
    close_out;
  end
endmodule // tb_pwm2_mode_control
